// ---- logic/dtca_cfg.svh ----
// Offsets, field positions, masks and reset values of the dual timer
`ifndef DTCA_CFG_SVH
`define DTCA_CFG_SVH
`define DTCA_AUX_CTL_OFS 16'hFF46
`define DTCA_CORE_CTL_OFS 16'hFF48
`define DTCA_CAP_OFS 16'hFF4A
`define DTCA_AUX_CNT_OFS 16'hFF4C
`define DTCA_CORE_CNT_OFS 16'hFF4E
`define DTCA_CTL_RST 16'h0000
`define DTCA_CNT_RST 16'h0000
`define DTCA_CORE_CTL_MASK 16'h87FF
`define DTCA_AUX_CTL_MASK 16'hF1DF
`define DTCA_CAP_EN_BIT 15
`define DTCA_RELOAD_BIT 15
`define DTCA_CLR_CAP_BIT 14
`define DTCA_CI_HI 13
`define DTCA_CI_LO 12
`define DTCA_OTL_BIT 10
`define DTCA_OE_BIT 9
`define DTCA_UDE_BIT 8
`define DTCA_UD_BIT 7
`define DTCA_RUN_BIT 6
`define DTCA_MODE_HI 5
`define DTCA_MODE_LO 3
`define DTCA_ISEL_HI 2
`define DTCA_ISEL_LO 0
`define DTCA_PIN_CNT 5
`define DTCA_MIN_LEVEL_CYC 4
`endif

// ---- logic/dtca_pkg.sv ----
// Types shared by the dual timer block
package dtca_pkg;
  typedef logic [15:0] dtca_word_t;
  typedef enum logic [2:0] {
    DTCA_TIMER = 3'b000,
    DTCA_COUNTER = 3'b001,
    DTCA_GATED_LO = 3'b010,
    DTCA_GATED_HI = 3'b011
  } dtca_mode_t;
  typedef struct packed {
    dtca_word_t core_ctl;
    dtca_word_t aux_ctl;
    dtca_word_t core_cnt;
    dtca_word_t aux_cnt;
    dtca_word_t cap;
    logic [8:0] pre;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    dtca_word_t rdata;
    logic pin;
  } dtca_state_t;
endpackage

// ---- logic/dtca_timer.sv ----
// Dual 16-bit up/down timer pair: core timer with toggle latch, auxiliary timer with capture
`timescale 1ns/100ps
`default_nettype none
`include "dtca_cfg.svh"

// Operation
// - Each core overflow or underflow inverts the core toggle latch.
// - Software writes set or clear the toggle latch directly.
// - Output enable 1 drives latch on pin, else pin carries general I/O.
// - Toggle latch feeds auxiliary counter internally, pin routing not needed.
// - Direction bit picks direction; with external enable, down when pin differs.
// - Both timers use the same direction logic with their own pin and bits.
// - Timer mode steps at clock over 4 times 2 to input select, 4 to 512.
// - Same eight prescaler choices for gated mode and the auxiliary timer.
// - Modes 010 and 011 gate; low mode bit gives gate polarity.
// - Gated mode advances only with run bit set and gate active.
// - Gate pin level changes raise no interrupt request.
// - Core counter mode counts none, rising, falling or either pin edge.
// - Auxiliary timer has same modes but no toggle latch or output pin.
// - Auxiliary mode: timer, counter, gated low, gated high.
// - Capture select: disabled, rising, falling or either capture pin edge.
// - Clear-on-capture set clears the auxiliary timer on capture.
// - Capture enable gates copying the auxiliary timer into capture register.
// - Shared functions sit at the same bit positions in both control registers.
// - Aux control: 15 capture, 14 clear, 13:12 edge, 8,7,6, 4:3, 2:0.
// - Core mode: timer, counter, gated low, gated high; upper codes reserved.
// - Each timer holds while its run bit is 0, except the aux timer, which a capture with clear set still zeroes.
// - Only overflow-caused latch changes clock the auxiliary counter.
module dtca_timer (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire dtca_pkg::dtca_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic core_gate_count_pin,
  input wire logic aux_gate_count_pin,
  input wire logic core_dir_pin,
  input wire logic aux_dir_pin,
  input wire logic capture_input_pin,
  input wire logic port3_gpio_data,
  output logic toggle_output_pin
);
  import dtca_pkg::*;

  localparam int PIN_CORE_GATE = 0;
  localparam int PIN_AUX_GATE = 1;
  localparam int PIN_CORE_DIR = 2;
  localparam int PIN_AUX_DIR = 3;
  localparam int PIN_CAP = 4;

  dtca_state_t q;
  dtca_state_t d;

  // Prescaler tick: every 4 << sel clocks
  function automatic logic presc_tick(input logic [8:0] pre, input logic [2:0] sel);
    logic [9:0] mask;
    mask = (10'h004 << sel) - 10'h001;
    return ({1'b0, pre} & mask) == mask;
  endfunction

  // Edge match for a two-bit edge code
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // Down when set; external enable makes pin level xor direction bit decide
  function automatic logic count_down(input logic ude, input logic ud, input logic pin);
    return ude ? (pin ^ ud) : ud;
  endfunction

  // Step decision shared by both timers
  function automatic logic step_ok(input dtca_mode_t mode, input logic run, input logic tick,
                                   input logic edge_evt, input logic gate);
    logic ok;
    ok = 1'b0;
    case (mode)
      DTCA_TIMER: ok = tick;
      DTCA_COUNTER: ok = edge_evt;
      DTCA_GATED_LO: ok = tick & ~gate;
      DTCA_GATED_HI: ok = tick & gate;
      default: ok = 1'b0;
    endcase
    return run & ok;
  endfunction

  logic [4:0] rise;
  logic [4:0] fall;
  logic wr_core_ctl, wr_aux_ctl, wr_core_cnt, wr_aux_cnt, wr_cap;
  dtca_mode_t core_mode, aux_mode;
  logic core_step, core_down, core_ovf;
  logic aux_step, aux_down, aux_edge, cap_evt;
  logic otl_new, otl_rise_evt, otl_fall_evt;

  // Edge detect on the second and third stages only
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;

  // Register write decode
  assign wr_core_ctl = reg_wr && reg_addr == `DTCA_CORE_CTL_OFS;
  assign wr_aux_ctl = reg_wr && reg_addr == `DTCA_AUX_CTL_OFS;
  assign wr_core_cnt = reg_wr && reg_addr == `DTCA_CORE_CNT_OFS;
  assign wr_aux_cnt = reg_wr && reg_addr == `DTCA_AUX_CNT_OFS;
  assign wr_cap = reg_wr && reg_addr == `DTCA_CAP_OFS;

  // Mode fields at the same position in both registers
  assign core_mode = dtca_mode_t'(q.core_ctl[`DTCA_MODE_HI:`DTCA_MODE_LO]);
  assign aux_mode = dtca_mode_t'({1'b0, q.aux_ctl[`DTCA_MODE_HI-1:`DTCA_MODE_LO]});

  // Core timer step, direction and overflow
  always_comb begin
    core_down = count_down(q.core_ctl[`DTCA_UDE_BIT], q.core_ctl[`DTCA_UD_BIT],
                           q.s2[PIN_CORE_DIR]);
    core_step = step_ok(core_mode, q.core_ctl[`DTCA_RUN_BIT],
                        presc_tick(q.pre, q.core_ctl[2:0]),
                        ~q.core_ctl[2] & edge_hit(q.core_ctl[1:0], rise[PIN_CORE_GATE],
                                                  fall[PIN_CORE_GATE]),
                        q.s2[PIN_CORE_GATE]);
    core_ovf = core_step && !wr_core_cnt &&
               (core_down ? q.core_cnt == 16'h0000 : q.core_cnt == 16'hFFFF);
  end

  // Toggle latch: overflow-caused changes alone clock the aux counter
  always_comb begin
    otl_new = q.core_ctl[`DTCA_OTL_BIT] ^ core_ovf;
    otl_rise_evt = core_ovf & otl_new;
    otl_fall_evt = core_ovf & ~otl_new;
  end

  // Auxiliary timer step, direction and capture
  always_comb begin
    aux_down = count_down(q.aux_ctl[`DTCA_UDE_BIT], q.aux_ctl[`DTCA_UD_BIT],
                          q.s2[PIN_AUX_DIR]);
    aux_edge = q.aux_ctl[2] ? edge_hit(q.aux_ctl[1:0], otl_rise_evt, otl_fall_evt)
                            : edge_hit(q.aux_ctl[1:0], rise[PIN_AUX_GATE],
                                       fall[PIN_AUX_GATE]);
    aux_step = step_ok(aux_mode, q.aux_ctl[`DTCA_RUN_BIT],
                       presc_tick(q.pre, q.aux_ctl[2:0]), aux_edge,
                       q.s2[PIN_AUX_GATE]);
    cap_evt = edge_hit(q.aux_ctl[`DTCA_CI_HI:`DTCA_CI_LO], rise[PIN_CAP],
                       fall[PIN_CAP]);
  end

  // Next state; gate pin changes only steer counting, nothing else
  always_comb begin
    d = q;
    d.pre = q.pre + 9'h001;
    d.s1 = {capture_input_pin, aux_dir_pin, core_dir_pin, aux_gate_count_pin,
            core_gate_count_pin};
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Core count; reload from capture register when enabled
    if (wr_core_cnt) begin
      d.core_cnt = reg_wdata;
    end else if (core_ovf && q.core_ctl[`DTCA_RELOAD_BIT]) begin
      d.core_cnt = q.cap;
    end else if (core_step) begin
      d.core_cnt = core_down ? q.core_cnt - 16'h0001 : q.core_cnt + 16'h0001;
    end
    // Core control; written latch value still toggles on a same-cycle overflow
    if (wr_core_ctl) begin
      d.core_ctl = reg_wdata & `DTCA_CORE_CTL_MASK;
    end
    d.core_ctl[`DTCA_OTL_BIT] = d.core_ctl[`DTCA_OTL_BIT] ^ core_ovf;
    if (wr_aux_ctl) begin
      d.aux_ctl = reg_wdata & `DTCA_AUX_CTL_MASK;
    end
    // Capture copies before clear
    if (wr_cap) begin
      d.cap = reg_wdata;
    end else if (cap_evt && q.aux_ctl[`DTCA_CAP_EN_BIT]) begin
      d.cap = q.aux_cnt;
    end
    if (wr_aux_cnt) begin
      d.aux_cnt = reg_wdata;
    end else if (cap_evt && q.aux_ctl[`DTCA_CLR_CAP_BIT]) begin
      d.aux_cnt = `DTCA_CNT_RST;
    end else if (aux_step) begin
      d.aux_cnt = aux_down ? q.aux_cnt - 16'h0001 : q.aux_cnt + 16'h0001;
    end
    // Pin shows latch only when enabled, else general I/O data
    d.pin = q.core_ctl[`DTCA_OE_BIT] ? q.core_ctl[`DTCA_OTL_BIT] : port3_gpio_data;
    // Read data for one cycle, unmapped reads zero
    d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `DTCA_CORE_CTL_OFS: d.rdata = q.core_ctl;
        `DTCA_AUX_CTL_OFS: d.rdata = q.aux_ctl;
        `DTCA_CORE_CNT_OFS: d.rdata = q.core_cnt;
        `DTCA_AUX_CNT_OFS: d.rdata = q.aux_cnt;
        `DTCA_CAP_OFS: d.rdata = q.cap;
        default: d.rdata = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign toggle_output_pin = q.pin;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Latch flips on overflow when not written
  toggle_flip_a: assert property (
    core_ovf && !wr_core_ctl |=> q.core_ctl[10] != $past(q.core_ctl[10]))
    else $error("toggle latch did not flip on overflow");

  // Software write lands in latch without overflow
  latch_write_a: assert property (
    wr_core_ctl && !core_ovf |=> q.core_ctl[10] == $past(reg_wdata[10]))
    else $error("toggle latch write lost");

  // Pin follows latch one cycle on while output enabled
  pin_follow_a: assert property (
    q.core_ctl[9] |=> toggle_output_pin == $past(q.core_ctl[10]))
    else $error("toggle pin does not follow latch");

  // Stopped core timer holds
  core_hold_a: assert property (
    !q.core_ctl[6] && !wr_core_cnt |=> q.core_cnt == $past(q.core_cnt))
    else $error("stopped core timer moved");

  // Up count adds exactly one
  core_up_a: assert property (
    core_step && !core_down && !wr_core_cnt && !core_ovf |=>
    q.core_cnt == 16'($past(q.core_cnt) + 16'h0001))
    else $error("core up count wrong");

  // Inactive gate holds core timer
  gate_hold_a: assert property (
    (core_mode == DTCA_GATED_HI && !q.s2[0] && !wr_core_cnt) |=>
    q.core_cnt == $past(q.core_cnt))
    else $error("core moved with gate inactive");

  // Timer mode fastest tick spacing is four clocks
  presc_space_a: assert property (
    core_mode == DTCA_TIMER && q.core_ctl[6] && q.core_ctl[2:0] == 3'b000 && core_step
    |=> !core_step [*3])
    else $error("prescaler tick spacing wrong");

  // Capture copies aux count
  cap_copy_a: assert property (
    cap_evt && q.aux_ctl[15] && !wr_cap |=> q.cap == $past(q.aux_cnt))
    else $error("capture copy missing");

  // Capture with clear zeroes aux count
  cap_clear_a: assert property (
    cap_evt && q.aux_ctl[14] && !wr_aux_cnt |=> q.aux_cnt == 16'h0000)
    else $error("aux not cleared on capture");

  // Aux steps on latch change only from overflow
  aux_chain_a: assert property (
    wr_core_ctl && !core_ovf && aux_mode == DTCA_COUNTER && q.aux_ctl[2] && !wr_aux_cnt
    && !cap_evt |=> q.aux_cnt == $past(q.aux_cnt))
    else $error("aux counted a software latch write");

  // Down count takes exactly one
  core_down_a: assert property (
    core_step && core_down && !wr_core_cnt && !core_ovf |=>
    q.core_cnt == 16'($past(q.core_cnt) - 16'h0001))
    else $error("core down count wrong");

  // Software direction while the pin is not in use
  soft_dir_a: assert property (
    !q.core_ctl[8] |-> core_down == q.core_ctl[7])
    else $error("core direction ignores direction bit");

  // Pin level equal to direction bit counts up
  pin_dir_a: assert property (
    q.core_ctl[8] && q.s2[2] == q.core_ctl[7] |-> !core_down)
    else $error("core direction pin not honoured");

  // Aux uses its own pin with the same rule
  aux_dir_a: assert property (
    q.aux_ctl[8] && q.s2[3] != q.aux_ctl[7] |-> aux_down)
    else $error("aux direction pin not honoured");

  // Aux down count takes exactly one
  aux_down_a: assert property (
    aux_step && aux_down && !wr_aux_cnt && !cap_evt |=>
    q.aux_cnt == 16'($past(q.aux_cnt) - 16'h0001))
    else $error("aux down count wrong");

  // Aux up count adds exactly one
  aux_up_a: assert property (
    aux_step && !aux_down && !wr_aux_cnt && !cap_evt |=>
    q.aux_cnt == 16'($past(q.aux_cnt) + 16'h0001))
    else $error("aux up count wrong");

  // Slowest prescaler tick is rare
  presc_slow_a: assert property (
    presc_tick(q.pre, 3'b111) |=> !presc_tick(q.pre, 3'b111) [*8])
    else $error("slow prescaler ticks too often");

  // Reserved core modes never step
  core_rsvd_a: assert property (
    q.core_ctl[5] |-> !core_step)
    else $error("reserved core mode stepped");

  // Disabled edge code 00 never counts
  cnt_off_a: assert property (
    core_mode == DTCA_COUNTER && q.core_ctl[1:0] == 2'b00 |-> !core_step)
    else $error("core counted with edges disabled");

  // Low-active gate held high stops the core
  gate_low_a: assert property (
    core_mode == DTCA_GATED_LO && q.s2[0] |-> !core_step)
    else $error("core ran with low-active gate high");

  // Aux gate follows its own pin
  aux_gate_a: assert property (
    aux_mode == DTCA_GATED_HI && !q.s2[1] |-> !aux_step)
    else $error("aux ran with gate inactive");

  // Stopped aux timer holds
  aux_hold_a: assert property (
    !q.aux_ctl[6] && !wr_aux_cnt && !cap_evt |=> q.aux_cnt == $past(q.aux_cnt))
    else $error("stopped aux timer moved");

  // Capture disabled keeps capture register
  cap_keep_a: assert property (
    cap_evt && !q.aux_ctl[15] && !wr_cap |=> q.cap == $past(q.cap))
    else $error("capture copied while disabled");

  // Capture without clear leaves a stopped aux count alone
  no_clear_a: assert property (
    cap_evt && !q.aux_ctl[14] && !q.aux_ctl[6] && !wr_aux_cnt |=>
    q.aux_cnt == $past(q.aux_cnt))
    else $error("aux cleared without clear bit");

  // Each overflow clocks a chained aux counter on either latch edge
  chain_step_a: assert property (
    core_ovf && aux_mode == DTCA_COUNTER && q.aux_ctl[6] && q.aux_ctl[2:0] == 3'b111
    |-> aux_step)
    else $error("aux missed a core overflow");

  // Pin shows general I/O while output disabled
  pin_gpio_a: assert property (
    !q.core_ctl[9] |=> toggle_output_pin == $past(port3_gpio_data))
    else $error("toggle pin does not follow general I/O");

  // Reload takes the capture register on overflow
  reload_a: assert property (
    core_ovf && q.core_ctl[15] && !wr_core_cnt |=> q.core_cnt == $past(q.cap))
    else $error("core reload missing");

  // Read data stands one cycle only
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outlived its cycle");

  // Scenario covers
  reload_c: cover property (core_ovf && q.core_ctl[15]);
  core_ovf_c: cover property (core_ovf);
  aux_chain_c: cover property (aux_step && q.aux_ctl[2] && aux_mode == DTCA_COUNTER);
  capture_c: cover property (cap_evt && q.aux_ctl[15] && q.aux_ctl[14]);
  gated_c: cover property (core_step && core_mode == DTCA_GATED_LO);
endmodule
`default_nettype wire

// ---- tb/dtca_pins_model.sv ----
// Pin driver model for the gate, count, direction and capture inputs
`timescale 1ns/100ps
`default_nettype none
module dtca_pins_model (
  input wire logic mclk,
  output logic core_gate_count_pin,
  output logic aux_gate_count_pin,
  output logic core_dir_pin,
  output logic aux_dir_pin,
  output logic capture_input_pin
);
  logic [4:0] pins_q = 5'h00;
  // Order: core gate, aux gate, core dir, aux dir, capture
  assign {capture_input_pin, aux_dir_pin, core_dir_pin, aux_gate_count_pin,
    core_gate_count_pin} = pins_q;
  // One pin changes after an edge, then holds six clocks
  task automatic set_pin(input int idx, input logic val);
    @(posedge mclk);
    pins_q[idx] <= val;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- tb/test_dual_timer_core_aux.sv ----
// Self-checking bench for the dual timer pair
`timescale 1ns/100ps
`default_nettype none
`include "dtca_cfg.svh"
module test_dual_timer_core_aux;
  import dtca_pkg::*;
  localparam logic [15:0] core_a = `DTCA_CORE_CTL_OFS;
  localparam logic [15:0] aux_a = `DTCA_AUX_CTL_OFS;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  dtca_word_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic cg_pin, ag_pin, cd_pin, ad_pin, cap_pin, toggle_output_pin;
  logic port3_gpio_data = 1'b0;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  dtca_pins_model pm (.mclk(mclk), .core_gate_count_pin(cg_pin), .aux_gate_count_pin(ag_pin),
    .core_dir_pin(cd_pin), .aux_dir_pin(ad_pin), .capture_input_pin(cap_pin));
  dtca_timer dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_gate_count_pin(cg_pin),
    .aux_gate_count_pin(ag_pin), .core_dir_pin(cd_pin), .aux_dir_pin(ad_pin),
    .capture_input_pin(cap_pin), .port3_gpio_data(port3_gpio_data),
    .toggle_output_pin(toggle_output_pin));
  // Compare and report
  task automatic chk(input string what, input dtca_word_t seen, input dtca_word_t exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus write with one idle cycle after
  task automatic wr(input logic [15:0] a, input dtca_word_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // Bus read, data taken in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input dtca_word_t exp, input string what);
    dtca_word_t v;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(what, v, exp);
    @(posedge mclk);
  endtask
  // Run a timer for exactly n clocks, then read its count
  task automatic run_t(input logic [15:0] ca, input dtca_word_t ctl, input int n,
    input dtca_word_t st, input dtca_word_t ex);
    wr(ca + 16'h0006, st);
    wr(ca, ctl);
    repeat (n - 2) @(posedge mclk);
    wr(ca, ctl & 16'hFFBF);
    rdc(ca + 16'h0006, ex, "count");
  endtask
  // Four pin toggles in counter mode
  task automatic cnt(input logic [15:0] ca, input dtca_word_t ctl, input int pin,
    input dtca_word_t ex);
    wr(ca + 16'h0006, 16'h0000);
    wr(ca, ctl);
    for (int i = 0; i < 4; i++) pm.set_pin(pin, i[0] == 1'b0);
    repeat (4) @(posedge mclk);
    wr(ca, 16'h0000);
    rdc(ca + 16'h0006, ex, "events");
  endtask
  // Output pin sampled mid-cycle
  task automatic pin_chk(input logic ex);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("toggle pin", {15'h0000, toggle_output_pin}, {15'h0000, ex});
    @(posedge mclk);
  endtask
  task automatic t_regs();
    rdc(aux_a, 16'h0000, "aux ctl reset");
    rdc(core_a, 16'h0000, "core ctl reset");
    rdc(16'hFF4E, 16'h0000, "core cnt reset");
    rdc(16'hFF40, 16'h0000, "unmapped");
    wr(aux_a, 16'hFFFF);
    wr(core_a, 16'hFFFF);
    rdc(aux_a, 16'hF1DF, "aux ctl bits");
    rdc(core_a, 16'h87FF, "core ctl bits");
    wr(aux_a, 16'h0000);
    wr(core_a, 16'h0000);
    $display("Test regs done");
  endtask
  task automatic t_dir();
    wr(16'hFF4C, 16'h0000);
    wr(aux_a, 16'h004F);
    run_t(core_a, 16'h0040, 40, 16'h0005, 16'h000F);
    run_t(core_a, 16'h00C0, 40, 16'h0005, 16'hFFFB);
    pm.set_pin(2, 1'b0);
    run_t(core_a, 16'h0140, 40, 16'h0005, 16'h000F);
    run_t(core_a, 16'h01C0, 40, 16'h0005, 16'hFFFB);
    pm.set_pin(2, 1'b1);
    run_t(core_a, 16'h0140, 40, 16'h0005, 16'hFFFB);
    run_t(core_a, 16'h01C0, 40, 16'h0005, 16'h000F);
    rdc(16'hFF4C, 16'h0003, "chained");
    wr(aux_a, 16'h0000);
    pm.set_pin(3, 1'b1);
    run_t(aux_a, 16'h0140, 40, 16'h0100, 16'h00F6);
    run_t(aux_a, 16'h01C0, 40, 16'h0100, 16'h010A);
    $display("Test dir done");
  endtask
  task automatic t_modes();
    run_t(core_a, 16'h0041, 80, 16'h0000, 16'h000A);
    run_t(core_a, 16'h0047, 1024, 16'h0000, 16'h0002);
    run_t(core_a, 16'h0050, 40, 16'h0000, 16'h000A);
    run_t(core_a, 16'h0058, 40, 16'h0000, 16'h0000);
    run_t(core_a, 16'h0000, 40, 16'h0007, 16'h0007);
    run_t(aux_a, 16'h0051, 80, 16'h0000, 16'h000A);
    run_t(aux_a, 16'h0058, 40, 16'h0000, 16'h0000);
    $display("Test modes done");
  endtask
  task automatic t_count();
    cnt(core_a, 16'h0048, 0, 16'h0000);
    cnt(core_a, 16'h0049, 0, 16'h0002);
    cnt(core_a, 16'h004A, 0, 16'h0002);
    cnt(core_a, 16'h004B, 0, 16'h0004);
    cnt(core_a, 16'h004C, 0, 16'h0000);
    cnt(aux_a, 16'h004B, 1, 16'h0004);
    $display("Test count done");
  endtask
  task automatic t_toggle();
    wr(core_a, 16'h0600);
    pin_chk(1'b1);
    wr(core_a, 16'h0400);
    rdc(core_a, 16'h0400, "latch");
    pin_chk(1'b0);
    port3_gpio_data <= 1'b1;
    pin_chk(1'b1);
    wr(core_a, 16'h0200);
    pin_chk(1'b0);
    port3_gpio_data <= 1'b0;
    wr(core_a, 16'h0000);
    $display("Test toggle done");
  endtask
  task automatic t_capture();
    wr(16'hFF4C, 16'h1234);
    wr(aux_a, 16'hD000);
    pm.set_pin(4, 1'b1);
    rdc(16'hFF4A, 16'h1234, "capture");
    rdc(16'hFF4C, 16'h0000, "cleared");
    wr(16'hFF4C, 16'h5678);
    wr(aux_a, 16'h6000);
    pm.set_pin(4, 1'b0);
    rdc(16'hFF4A, 16'h1234, "no copy");
    rdc(16'hFF4C, 16'h0000, "cleared");
    wr(16'hFF4C, 16'h00AA);
    wr(aux_a, 16'hB000);
    pm.set_pin(4, 1'b1);
    rdc(16'hFF4A, 16'h00AA, "capture");
    wr(aux_a, 16'hC000);
    pm.set_pin(4, 1'b0);
    rdc(16'hFF4C, 16'h00AA, "kept");
    run_t(core_a, 16'h80C0, 40, 16'h0002, 16'h00A3);
    $display("Test capture done");
  endtask
  // Closing report
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_dir();
    t_modes();
    t_count();
    t_toggle();
    t_capture();
    end_sim();
  end
endmodule
`default_nettype wire
